/* File: hdl/pbdt_pkg.sv */
package pbdt_pkg;
  // data path geometry
  localparam int DATA_W      = 64;
  localparam int LANES       = 8;
  localparam int BYTE_W      = 8;
  localparam int ADDR_W      = 32;
  // tenure queue geometry
  localparam int QUEUE_DEPTH = 16;
  localparam int IDX_W       = 4;
  // beats per tenure kind
  localparam logic [2:0] BEATS_LINE   = 3'h4;
  localparam logic [2:0] BEATS_VECTOR = 3'h2;
  localparam logic [2:0] BEATS_SINGLE = 3'h1;
  // address alignment masks (low bits cleared) and the one-dword beat step
  localparam logic [ADDR_W-1:0] DWORD_MASK = 32'hFFFFFFF8;
  localparam logic [ADDR_W-1:0] QWORD_MASK = 32'hFFFFFFF0;
  localparam logic [ADDR_W-1:0] LINE_MASK  = 32'hFFFFFFE0;
  localparam logic [ADDR_W-1:0] DWORD_STEP = 32'h00000008;
  // transfer-buffer depth
  localparam int FIFO_DEPTH  = 16;
  localparam int FIFO_W      = DATA_W;
  // kinds of tenure carried by a queue entry
  typedef enum logic [1:0] {
    PBDT_LINE_MISS,   // cacheable miss, critical word first
    PBDT_LINE_OTHER,  // line-aligned burst
    PBDT_VECTOR,      // two-beat quad-aligned burst
    PBDT_SINGLE       // one beat, one to eight bytes
  } pbdt_kind_t;

  // one queue entry
  typedef struct packed {
    logic              is_write;
    pbdt_kind_t        kind;
    logic [ADDR_W-1:0] addr;
  } pbdt_entry_t;

  // odd parity for every byte lane
  function automatic logic [LANES-1:0] pbdt_odd_parity(
    input logic [DATA_W-1:0] d);
    logic [LANES-1:0] p;
    p = '0;
    for (int n = 0; n < LANES; n++) begin
      p[n] = ~(^d[n*BYTE_W +: BYTE_W]);
    end
    return p;
  endfunction

  // beat count per kind
  function automatic logic [2:0] pbdt_beats(input pbdt_kind_t k);
    logic [2:0] b;
    b = BEATS_SINGLE;
    unique case (k)
      PBDT_LINE_MISS, PBDT_LINE_OTHER: b = BEATS_LINE;
      PBDT_VECTOR:                     b = BEATS_VECTOR;
      PBDT_SINGLE:                     b = BEATS_SINGLE;
    endcase
    return b;
  endfunction
endpackage

/* File: hdl/pbdt_bus_if.sv */
interface pbdt_bus_if;
  import pbdt_pkg::*;
  logic                 address_phase_begin;       // tenure start, high
  logic                 address_phase_acknowledge; // address ack
  logic                 address_retry;             // retry in window
  logic                 data_only_hit;             // hit: data-only entry
  logic                 data_grant;                // data bus grant
  logic [IDX_W-1:0]     tenure_queue_index;        // age index
  logic                 transfer_acknowledge;      // one beat moved
  logic                 same_source;               // next tenure same driver
  logic [DATA_W-1:0]    dev_data;                  // device-driven data
  logic [LANES-1:0]     dev_parity;                // its byte_parity_lines
  logic                 dev_data_oe_n;             // low while driving
  logic [DATA_W-1:0]    sys_data;                  // system-driven data
  logic [LANES-1:0]     sys_parity;                // its byte_parity_lines
  modport device (
    input  address_phase_acknowledge, address_retry, data_grant,
           tenure_queue_index, transfer_acknowledge, same_source,
           sys_data, sys_parity,
    output address_phase_begin, data_only_hit, dev_data, dev_parity,
           dev_data_oe_n
  );
  modport system (
    output address_phase_acknowledge, address_retry, data_grant,
           tenure_queue_index, transfer_acknowledge, same_source,
           sys_data, sys_parity,
    input  address_phase_begin, data_only_hit, dev_data, dev_parity,
           dev_data_oe_n
  );
endinterface

/* File: hdl/pbdt_fifo.sv */
module pbdt_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 16
) (
  input  wire logic             clock,
  input  wire logic             arst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];   // flip-flop storage
  logic [AW-1:0]    wr_ptr;        // write index
  logic [AW-1:0]    rd_ptr;        // read index
  logic [AW:0]      count;         // fill level
  logic             push;
  logic             pop;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr];

  // storage write
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // pointers and level
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // pbdt_fifo

/* File: hdl/pbdt_device.sv */
module pbdt_device
  import pbdt_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              arst_n,
  pbdt_bus_if.device             bus,
  input  wire logic              req_valid,        // new tenure request
  output logic                   req_ready,        // queue has room
  input  wire logic              req_data_only,    // hit-type entry
  input  wire logic              req_write,
  input  wire pbdt_kind_t        req_kind,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [IDX_W:0]    queue_depth_field, // 1..16 programmed
  input  wire logic              wr_valid,         // write beat in
  output logic                   wr_ready,
  input  wire logic [DATA_W-1:0] wr_data,
  output logic                   rd_valid,         // read beat out
  input  wire logic              rd_ready,
  output logic      [DATA_W-1:0] rd_data,
  output logic      [ADDR_W-1:0] beat_addr,        // current beat address
  input  wire logic              parity_check_enable,
  input  wire logic              machine_check_enable,
  output logic                   machine_check,    // one-cycle pulse
  output logic                   checkstop         // sticky
);
  pbdt_entry_t       queue [QUEUE_DEPTH];  // age ordered, 0 oldest
  logic [IDX_W:0]    level;                // valid entries
  logic [IDX_W-1:0]  idx_q;                // index sampled last cycle
  logic              active;               // tenure in progress
  pbdt_entry_t       cur;                  // tenure being served
  logic [2:0]        beats_left;
  logic [ADDR_W-1:0] addr_q;
  logic              retry_seen;           // retry hit newest entry
  logic              qual_grant;
  logic              push_q;
  logic              pop_q;
  logic              drop_new;
  logic              wf_valid;
  logic              wf_ready;
  logic [DATA_W-1:0] wf_data;
  logic              rf_ready;
  logic              rf_push;
  logic              last_beat;

  assign req_ready = (level < queue_depth_field)
                     && (level < (IDX_W+1)'(QUEUE_DEPTH));
  assign push_q = req_valid && req_ready;
  assign bus.address_phase_begin = push_q && !req_data_only;
  assign bus.data_only_hit       = push_q && req_data_only;
  assign drop_new = bus.address_retry && !retry_seen && (level != '0);
  assign last_beat = active && bus.transfer_acknowledge
                     && (beats_left == BEATS_SINGLE);

  always_comb begin
    qual_grant = bus.data_grant && !bus.address_retry && (level != '0);
    if (active) begin
      qual_grant = qual_grant && last_beat && bus.same_source
                   && (pbdt_beats(cur.kind) != BEATS_SINGLE);
    end
  end
  assign pop_q = qual_grant;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      idx_q <= '0;
    end else begin
      idx_q <= bus.tenure_queue_index;
    end
  end

  // retry marker for newest entry, cleared by the next append
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      retry_seen <= 1'b0;
    end else if (push_q) begin
      retry_seen <= 1'b0;
    end else if (drop_new) begin
      retry_seen <= 1'b1;
    end
  end

  // queue with shift-forward removal
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      level <= '0;
      for (int i = 0; i < QUEUE_DEPTH; i++) begin
        queue[i] <= '0;
      end
    end else begin
      // index is age; zero is oldest
      for (int i = 0; i < QUEUE_DEPTH - 1; i++) begin
        if (pop_q && i >= int'(idx_q)) begin
          queue[i] <= queue[i+1];
        end
      end
      if (push_q) begin
        queue[int'(level) - int'(pop_q)].is_write <= req_write;
        queue[int'(level) - int'(pop_q)].kind     <= req_kind;
        queue[int'(level) - int'(pop_q)].addr     <= req_addr;
      end
      level <= level + (IDX_W+1)'(push_q) - (IDX_W+1)'(pop_q)
               - (IDX_W+1)'(drop_new && !pop_q);
    end
  end

  function automatic logic [ADDR_W-1:0] start_addr(input pbdt_entry_t e);
    logic [ADDR_W-1:0] a;
    a = e.addr;
    unique case (e.kind)
      PBDT_LINE_MISS:  a = e.addr & DWORD_MASK;
      PBDT_LINE_OTHER: a = e.addr & LINE_MASK;
      PBDT_VECTOR:     a = e.addr & QWORD_MASK;
      PBDT_SINGLE:     a = e.addr;
    endcase
    return a;
  endfunction

  // tenure starts the cycle after grant
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      active     <= 1'b0;
      cur        <= '0;
      beats_left <= '0;
      addr_q     <= '0;
    end else if (qual_grant) begin
      active     <= 1'b1;
      cur        <= queue[idx_q];
      beats_left <= pbdt_beats(queue[idx_q].kind);
      addr_q     <= start_addr(queue[idx_q]);
    end else if (active && bus.transfer_acknowledge) begin
      beats_left <= beats_left - 3'h1;
      // wrap inside the line for critical-word-first order
      addr_q <= (addr_q & LINE_MASK) | ((addr_q + DWORD_STEP) & ~LINE_MASK);
      if (beats_left == BEATS_SINGLE) begin
        active <= 1'b0;
      end
    end
  end
  assign beat_addr = addr_q;

  // write data buffer
  pbdt_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_wr_fifo (
    .clock     (clock),
    .arst_n    (arst_n),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .in_data   (wr_data),
    .out_valid (wf_valid),
    .out_ready (wf_ready),
    .out_data  (wf_data)
  );
  assign wf_ready = active && cur.is_write && bus.transfer_acknowledge;

  // drive 64-bit data with odd parity
  assign bus.dev_data      = wf_data;
  assign bus.dev_parity    = pbdt_odd_parity(wf_data);
  assign bus.dev_data_oe_n = !(active && cur.is_write && wf_valid);

  // read data buffer; rf_ready is unused, so grants are not held back and a beat arriving while full is dropped
  assign rf_push = active && !cur.is_write && bus.transfer_acknowledge;
  pbdt_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_rd_fifo (
    .clock     (clock),
    .arst_n    (arst_n),
    .in_valid  (rf_push),
    .in_ready  (rf_ready),
    .in_data   (bus.sys_data),
    .out_valid (rd_valid),
    .out_ready (rd_ready),
    .out_data  (rd_data)
  );

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      machine_check <= 1'b0;
      checkstop     <= 1'b0;
    end else begin
      machine_check <= 1'b0;
      if (rf_push && parity_check_enable &&
          (pbdt_odd_parity(bus.sys_data) != bus.sys_parity)) begin
        if (machine_check_enable) begin
          machine_check <= 1'b1;
        end else begin
          checkstop <= 1'b1;
        end
      end
    end
  end
endmodule // pbdt_device

/* File: hdl/pbdt_system.sv */
module pbdt_system
  import pbdt_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              arst_n,
  pbdt_bus_if.system             bus,
  input  wire logic              retry_req,     // retry this start
  input  wire logic              grant_req,     // wish to grant a tenure
  input  wire logic [IDX_W-1:0]  grant_index,   // which queued tenure
  input  wire logic              grant_write,   // tenure is a write
  input  wire logic [2:0]        grant_beats,   // beats of that tenure
  input  wire logic              grant_same_src,
  input  wire logic [DATA_W-1:0] read_data,     // data to send on reads
  output logic                   grant_done,    // grant issued, pulse
  output logic      [DATA_W-1:0] write_data,    // last received write
  output logic                   write_strobe   // pulse per write beat
);
  logic [IDX_W:0]   level;      // mirror of device queue
  logic [1:0]       snoop;      // address phase age
  logic             pending;    // grant waiting on index setup
  logic [2:0]       beats;
  logic             wr_q;
  logic             busy;
  logic             gap;        // one idle cycle after tenure

  // address ack then retry window; data waits for window end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      snoop <= '0;
    end else if (bus.address_phase_begin || bus.data_only_hit) begin
      snoop <= 2'h2;
    end else if (snoop != '0) begin
      snoop <= snoop - 2'h1;
    end
  end
  assign bus.address_phase_acknowledge = (snoop == 2'h2);
  assign bus.address_retry = (snoop == 2'h1) && retry_req;

  // queue mirror
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      level <= '0;
    end else begin
      level <= level
        + (IDX_W+1)'(bus.address_phase_begin || bus.data_only_hit)
        - (IDX_W+1)'(bus.data_grant)
        - (IDX_W+1)'(bus.address_retry);
    end
  end

  // index the cycle before grant; index legal
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pending <= 1'b0;
    end else begin
      pending <= grant_req && !pending && !busy && !gap && snoop == '0
                 && (IDX_W+1)'(grant_index) < level;
    end
  end
  assign bus.tenure_queue_index = grant_index;
  assign bus.data_grant         = pending;
  assign bus.same_source        = grant_same_src;
  assign grant_done             = pending;

  // tenure beats and acknowledges
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      busy  <= 1'b0;
      beats <= '0;
      wr_q  <= 1'b0;
      gap   <= 1'b0;
    end else begin
      gap <= busy && beats == BEATS_SINGLE;
      if (pending) begin
        busy  <= 1'b1;
        beats <= grant_beats;
        wr_q  <= grant_write;
      end else if (busy) begin
        beats <= beats - 3'h1;
        if (beats == BEATS_SINGLE) begin
          busy <= 1'b0;
        end
      end
    end
  end
  assign bus.transfer_acknowledge = busy;
  assign bus.sys_data   = read_data;
  assign bus.sys_parity = pbdt_odd_parity(read_data);

  // capture write beats
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      write_data   <= '0;
      write_strobe <= 1'b0;
    end else begin
      write_strobe <= busy && wr_q;
      if (busy && wr_q) begin
        write_data <= bus.dev_data;
      end
    end
  end
endmodule // pbdt_system

/* File: verif/pbdt_chk.sv */
module pbdt_chk
  import pbdt_pkg::*;
(
  input wire logic              clock,
  input wire logic              arst_n,
  input wire logic              address_phase_begin,
  input wire logic              address_phase_acknowledge,
  input wire logic              address_retry,
  input wire logic              data_only_hit,
  input wire logic              data_grant,
  input wire logic [IDX_W-1:0]  tenure_queue_index,
  input wire logic              transfer_acknowledge,
  input wire logic              dev_data_oe_n,
  input wire logic [DATA_W-1:0] dev_data,
  input wire logic [LANES-1:0]  dev_parity
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [4:0]       q_cnt;    // entries the device holds
  logic             ack_seen; // an address ack has occurred
  logic [1:0]       age;      // cycles since reset, saturating
  logic [LANES-1:0] exp_par;  // odd parity of the driven word

  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  // odd parity per lane, worked out independently
  always_comb begin
    for (int n = 0; n < LANES; n++) begin
      exp_par[n] = ~(^dev_data[n*8 +: 8]);
    end
  end

  // queue occupancy from starts, hits, retries and grants
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      q_cnt <= 5'h00;
    end else begin
      q_cnt <= q_cnt + 5'(address_phase_begin) + 5'(data_only_hit)
             - 5'(address_retry) - 5'(data_grant);
    end
  end

  // remembers the first address ack, and settles after reset
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ack_seen <= 1'b0;
      age      <= 2'h0;
    end else begin
      ack_seen <= ack_seen | address_phase_acknowledge;
      age      <= (age == 2'h3) ? age : age + 2'h1;
    end
  end

  // address phase: start then its ack
  sequence s_addr_phase;
    address_phase_begin ##1 address_phase_acknowledge;
  endsequence

  AST_ACK_AFTER_BEGIN: assert property (address_phase_begin |-> s_addr_phase)
    else $error("no address ack after start");
  AST_RETRY_IN_WINDOW: assert property (
    address_retry |-> $past(address_phase_acknowledge))
    else $error("retry outside its window");
  AST_TA_AFTER_ACK: assert property (transfer_acknowledge |-> ack_seen)
    else $error("beat ack before any address ack");
  AST_INDEX_LEGAL: assert property (data_grant |-> q_cnt != 5'h00 &&
    ({1'b0, $past(tenure_queue_index)} < q_cnt ||
     $past(tenure_queue_index) == 4'h0))
    else $error("grant with unmatched index");
  AST_QUEUE_LIMIT: assert property (q_cnt <= 5'h10)
    else $error("more than sixteen queued");
  AST_DRIVE_AFTER_GRANT: assert property (
    $fell(dev_data_oe_n) |-> $past(data_grant))
    else $error("drive began without a grant");
  AST_RELEASE_AFTER_TA: assert property (
    $rose(dev_data_oe_n) && age == 2'h3 |-> $past(transfer_acknowledge))
    else $error("drive released without final ack");
  AST_PARITY_ODD: assert property (
    !dev_data_oe_n && transfer_acknowledge |-> dev_parity == exp_par)
    else $error("write parity not odd");
  AST_GRANT_PULSE: assert property (data_grant |=> !data_grant)
    else $error("grant held two cycles");
  AST_DATA_AFTER_WINDOW: assert property (
    s_addr_phase |-> !transfer_acknowledge ##1 !transfer_acknowledge)
    else $error("data moved in snoop window");
endmodule // pbdt_chk

/* File: verif/processor_bus_data_tenure_tb.sv */
module processor_bus_data_tenure_tb
  import pbdt_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic              wr;
    pbdt_kind_t        kind;
    logic [ADDR_W-1:0] addr;
  } pbdt_row_t;
  // ordinary cases: writes use up the sixteen buffered words
  pbdt_row_t rows [9] = '{
    '{1'b1, PBDT_LINE_MISS, 32'h00001018}, '{1'b1, PBDT_LINE_OTHER, 32'h00002018},
    '{1'b1, PBDT_VECTOR, 32'h00003018}, '{1'b1, PBDT_SINGLE, 32'h00004003},
    '{1'b1, PBDT_LINE_MISS, 32'h00005008}, '{1'b1, PBDT_SINGLE, 32'h00006000},
    '{1'b0, PBDT_LINE_MISS, 32'h00007010}, '{1'b0, PBDT_VECTOR, 32'h00008008},
    '{1'b0, PBDT_SINGLE, 32'h00009005}};
  logic clock = 1'b0, arst_n = 1'b0;
  logic req_valid, req_ready, req_write, wr_valid, wr_ready, rd_valid;
  logic rd_ready, mc, cs, retry_req, grant_req, grant_write, grant_done;
  logic write_strobe, r2_valid, pce2, mce2, mc2, cs2, dao;
  pbdt_kind_t        req_kind;
  logic [ADDR_W-1:0] req_addr, beat_addr;
  logic [IDX_W:0]    depth;
  logic [IDX_W-1:0]  grant_index;
  logic [2:0]        grant_beats;
  logic [DATA_W-1:0] wr_data, rd_data, read_data, write_data;
  logic [ADDR_W-1:0] aq [$]; // beat addresses seen
  logic [DATA_W-1:0] dq [$]; // data beats seen
  int bad_count = 0, checked = 0, cycles = 0, mc_seen = 0, wi = 0, n;

  pbdt_bus_if u_pbdt_bus_if ();
  pbdt_bus_if u_pbdt_bus_if_2 ();
  pbdt_device u_pbdt_device (.clock(clock), .arst_n(arst_n),
    .bus(u_pbdt_bus_if), .req_valid(req_valid), .req_ready(req_ready),
    .req_data_only(dao), .req_write(req_write), .req_kind(req_kind),
    .req_addr(req_addr), .queue_depth_field(depth), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .rd_data(rd_data), .beat_addr(beat_addr),
    .parity_check_enable(1'b1), .machine_check_enable(1'b1),
    .machine_check(mc), .checkstop(cs));
  pbdt_system u_pbdt_system (.clock(clock), .arst_n(arst_n),
    .bus(u_pbdt_bus_if), .retry_req(retry_req), .grant_req(grant_req),
    .grant_index(grant_index), .grant_write(grant_write),
    .grant_beats(grant_beats), .grant_same_src(1'b0),
    .read_data(read_data), .grant_done(grant_done),
    .write_data(write_data), .write_strobe(write_strobe));
  // second device faces a bench-driven far side that breaks parity
  pbdt_device u_pbdt_device_2 (.clock(clock), .arst_n(arst_n),
    .bus(u_pbdt_bus_if_2), .req_valid(r2_valid), .req_ready(),
    .req_data_only(dao), .req_write(1'b0), .req_kind(req_kind),
    .req_addr(req_addr), .queue_depth_field(depth), .wr_valid(1'b0),
    .wr_ready(), .wr_data(wr_data), .rd_valid(), .rd_ready(rd_ready),
    .rd_data(), .beat_addr(), .parity_check_enable(pce2),
    .machine_check_enable(mce2), .machine_check(mc2), .checkstop(cs2));
  pbdt_chk u_pbdt_chk (.clock(clock), .arst_n(arst_n),
    .address_phase_begin(u_pbdt_bus_if.address_phase_begin),
    .address_phase_acknowledge(u_pbdt_bus_if.address_phase_acknowledge),
    .address_retry(u_pbdt_bus_if.address_retry),
    .data_only_hit(u_pbdt_bus_if.data_only_hit),
    .data_grant(u_pbdt_bus_if.data_grant),
    .tenure_queue_index(u_pbdt_bus_if.tenure_queue_index),
    .transfer_acknowledge(u_pbdt_bus_if.transfer_acknowledge),
    .dev_data_oe_n(u_pbdt_bus_if.dev_data_oe_n),
    .dev_data(u_pbdt_bus_if.dev_data), .dev_parity(u_pbdt_bus_if.dev_parity));

  always #12.5 clock = ~clock;

  // buffered write word n, bytes varied so parity varies
  function automatic logic [DATA_W-1:0] wd(input int k);
    return 64'h0123456789ABCDEF ^ {8{8'(k * 37)}};
  endfunction
  // odd parity of every byte lane
  function automatic logic [7:0] par(input logic [DATA_W-1:0] d);
    for (int i = 0; i < 8; i++) par[i] = ~(^d[i*8 +: 8]);
  endfunction
  function automatic int nb(input pbdt_kind_t k);
    return (k == PBDT_SINGLE) ? 1 : (k == PBDT_VECTOR) ? 2 : 4;
  endfunction
  // address of beat i: miss wraps from critical dword, line and vector aligned, single as given
  function automatic logic [31:0] ea(pbdt_kind_t k, logic [31:0] a, int i);
    case (k)
      PBDT_LINE_MISS:  return {a[31:5], 2'(a[4:3] + i), 3'h0};
      PBDT_LINE_OTHER: return {a[31:5], 2'(i), 3'h0};
      PBDT_VECTOR:     return {a[31:4], 1'(i), 3'h0};
      default:         return a;
    endcase
  endfunction

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // one request, held until taken, then its address phase runs out
  task automatic send_req(logic w, pbdt_kind_t k, logic [31:0] a, logic r);
    int t;
    @(negedge clock);
    {req_valid, req_write, req_addr, retry_req} = {1'b1, w, a, r};
    req_kind = k;
    for (t = 0; t < 50 && req_ready !== 1'b1; t++) @(negedge clock);
    @(negedge clock);
    req_valid = 1'b0;
    repeat (4) @(negedge clock);
    retry_req = 1'b0;
  endtask
  // grant one tenure, optionally stall the read side, compare beats
  task automatic run_tenure(logic [3:0] idx, logic w, pbdt_kind_t k,
      logic [31:0] a, logic [63:0] rv, logic stall);
    int t;
    int b;
    b = nb(k);
    aq.delete();
    dq.delete();
    @(negedge clock);
    {grant_req, grant_index, grant_write, grant_beats} = {1'b1, idx, w, 3'(b)};
    read_data = rv;
    rd_ready = !stall;
    for (t = 0; t < 50 && grant_done !== 1'b1; t++) @(negedge clock);
    grant_req = 1'b0;
    for (t = 0; t < 50 && aq.size() < b; t++) @(negedge clock);
    repeat (stall ? 8 : 0) @(negedge clock);
    rd_ready = 1'b1;
    for (t = 0; t < 50 && dq.size() < b; t++) @(negedge clock);
    chk(64'(aq.size()), 64'(b));
    chk(64'(dq.size()), 64'(b));
    for (int i = 0; i < b && i < aq.size() && i < dq.size(); i++) begin
      chk(64'(aq[i]), 64'(ea(k, a, i)));
      chk(dq[i], w ? wd(wi + i) : rv);
    end
    if (w) wi += b;
    repeat (2) @(negedge clock);
  endtask
  // read on the second device with one lane of parity wrong
  task automatic bad_read(logic pce, logic mce, int emc, logic ecs);
    int t;
    {pce2, mce2, mc_seen} = {pce, mce, 32'd0};
    @(negedge clock);
    r2_valid = 1'b1;
    for (t = 0; t < 20 && u_pbdt_bus_if_2.address_phase_begin !== 1'b1; t++)
      @(negedge clock);
    @(negedge clock);
    r2_valid = 1'b0;
    @(negedge clock);
    u_pbdt_bus_if_2.address_phase_acknowledge = 1'b1;
    @(negedge clock);
    u_pbdt_bus_if_2.address_phase_acknowledge = 1'b0;
    @(negedge clock);
    u_pbdt_bus_if_2.data_grant = 1'b1;
    @(negedge clock);
    u_pbdt_bus_if_2.data_grant = 1'b0;
    u_pbdt_bus_if_2.transfer_acknowledge = 1'b1;
    u_pbdt_bus_if_2.sys_data = 64'h0;
    u_pbdt_bus_if_2.sys_parity = 8'hFE;
    @(negedge clock);
    u_pbdt_bus_if_2.transfer_acknowledge = 1'b0;
    u_pbdt_bus_if_2.sys_data = ~u_pbdt_bus_if_2.sys_data;
    u_pbdt_bus_if_2.sys_parity = ~u_pbdt_bus_if_2.sys_parity;
    repeat (5) @(negedge clock);
    chk(64'(mc_seen), 64'(emc));
    chk(64'(cs2), 64'(ecs));
  endtask

  // collect handshakes at the edge where they complete
  always @(posedge clock) begin
    cycles++;
    if (u_pbdt_bus_if.transfer_acknowledge === 1'b1) aq.push_back(beat_addr);
    if (u_pbdt_bus_if.transfer_acknowledge === 1'b1 &&
        u_pbdt_bus_if.dev_data_oe_n === 1'b0)
      chk(64'(u_pbdt_bus_if.dev_parity), 64'(par(u_pbdt_bus_if.dev_data)));
    if (write_strobe === 1'b1) dq.push_back(write_data);
    if (rd_valid === 1'b1 && rd_ready === 1'b1) dq.push_back(rd_data);
    if (mc2 === 1'b1) mc_seen++;
    if (mc === 1'b1) chk(64'(mc), 64'h0);
    if (cycles == 20000) begin
      bad_count++;
      end_sim();
    end
  end

  initial begin
    {req_valid, req_write, retry_req, grant_req, grant_write} = '0;
    {dao, wr_valid, r2_valid, pce2, mce2, rd_ready} = 6'h01;
    {req_addr, grant_index, grant_beats} = '0;
    req_kind = PBDT_LINE_MISS;
    {depth, wr_data, read_data} = {5'h10, 128'h0};
    {u_pbdt_bus_if_2.address_phase_acknowledge, u_pbdt_bus_if_2.data_grant} = '0;
    {u_pbdt_bus_if_2.address_retry, u_pbdt_bus_if_2.same_source} = '0;
    u_pbdt_bus_if_2.transfer_acknowledge = 1'b0;
    u_pbdt_bus_if_2.tenure_queue_index = 4'h0;
    {u_pbdt_bus_if_2.sys_data, u_pbdt_bus_if_2.sys_parity} = '0;
    repeat (20) @(posedge clock);
    @(negedge clock);
    arst_n = 1'b1;
    @(negedge clock);
    chk(64'(req_ready), 64'h1);
    chk(64'(rd_valid), 64'h0);
    chk(64'(cs), 64'h0);
    $display("test reset done");
    // fill the write buffer until it refuses
    wr_valid = 1'b1;
    n = 0;
    repeat (20) begin
      wr_data = wd(n);
      if (wr_ready === 1'b1) n++;
      @(negedge clock);
    end
    wr_valid = 1'b0;
    chk(64'(n), 64'(FIFO_DEPTH));
    $display("test buffer fill done");
    foreach (rows[i]) begin
      send_req(rows[i].wr, rows[i].kind, rows[i].addr, 1'b0);
      run_tenure(4'h0, rows[i].wr, rows[i].kind, rows[i].addr,
                 {32'hA5A50000, 32'(i)}, i == 6);
      $display("test row %0d done", i);
    end
    // depth limit, out-of-order service, then a retried start
    depth = 5'h02;
    send_req(1'b0, PBDT_SINGLE, 32'h0000A000, 1'b0);
    send_req(1'b0, PBDT_SINGLE, 32'h0000B000, 1'b0);
    chk(64'(req_ready), 64'h0);
    run_tenure(4'h1, 1'b0, PBDT_SINGLE, 32'h0000B000, 64'hB, 1'b0);
    run_tenure(4'h0, 1'b0, PBDT_SINGLE, 32'h0000A000, 64'hA, 1'b0);
    depth = 5'h10;
    send_req(1'b0, PBDT_SINGLE, 32'h0000C000, 1'b1);
    dao = 1'b1;
    send_req(1'b0, PBDT_SINGLE, 32'h0000D000, 1'b0);
    dao = 1'b0;
    run_tenure(4'h0, 1'b0, PBDT_SINGLE, 32'h0000D000, 64'hD, 1'b0);
    $display("test reorder done");
    bad_read(1'b0, 1'b1, 0, 1'b0);
    bad_read(1'b1, 1'b1, 1, 1'b0);
    bad_read(1'b1, 1'b0, 0, 1'b1);
    $display("test parity fault done");
    end_sim();
  end
endmodule // processor_bus_data_tenure_tb
